// [hw/exec_unit_pkg.sv]
/*
  Shared constants for the three-instruction execution block.
  Assumes a 14-bit instruction word and 8-bit data path.
*/
package exec_unit_pkg;
  localparam int INSTR_W = 14;              // Instruction word width
  localparam int DATA_W  = 8;               // Data width
  localparam int FADDR_W = 7;               // File address width
  localparam int ROM_W   = 14;              // Program-memory word width
  localparam int ROM_AW  = 12;              // Program-memory address width
  // Opcode field positions
  localparam int OP_HI     = 13;            // Top of opcode field
  localparam int OP_LO     = 8;             // Bottom of opcode field
  localparam int DEST_BIT  = 7;             // Destination select bit
  localparam logic [5:0] OPC_SUB  = 6'h02;  // Subtract accumulator from file
  localparam logic [5:0] OPC_SWAP = 6'h0e;  // Nibble swap
  localparam logic [13:0] OPC_TRH = 14'h0058; // Table read high, full word
  localparam logic [7:0] ACC_RESET = 8'h00; // Accumulator after reset
  localparam int TRH_CYCLES = 2;            // Table read length in cycles
  localparam logic [1:0] TRH_LAST = 2'h1;   // Counter value of last cycle
endpackage

// [hw/nibble_sub_alu.sv]
/*
  Combinational arithmetic for subtract and nibble swap.
  Assumes operands are stable during the execute cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module nibble_sub_alu
  import exec_unit_pkg::*;
(
  input  wire logic [DATA_W-1:0] file_i,    // File register operand
  input  wire logic [DATA_W-1:0] acc_i,     // Accumulator operand
  output logic      [DATA_W-1:0] diff_o,    // File minus accumulator
  output logic      [DATA_W-1:0] swap_o,    // Swapped file value
  output logic                   carry_o,   // Set when no borrow
  output logic                   half_o,    // Set when no nibble borrow
  output logic                   zero_o     // Difference is zero
);
  logic [DATA_W:0] wide;                    // Nine-bit sum
  logic [4:0]      low;                     // Low nibble sum

  // Two's complement: file + ~acc + 1
  always_comb begin
    wide    = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
    low     = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    diff_o  = wide[DATA_W-1:0];
    carry_o = wide[DATA_W];
    half_o  = low[4];
    zero_o  = (wide[DATA_W-1:0] == 8'h00);
    swap_o  = {file_i[3:0], file_i[7:4]};
  end
endmodule // nibble_sub_alu
`default_nettype wire

// [hw/sub_swap_tabrd.sv]
/*
  Execution of subtract-from-file, nibble swap and table read high.
  Assumes the core presents one instruction per INSTR_VALID_I pulse,
  file data for the addressed register in the same cycle, and program
  memory that answers one cycle after an address is presented.
*/
// Behaviour
// - Subtract accumulator from file, update flags
// - Subtract result to accumulator or file by bit
// - Swap register nibbles, leave flags unchanged
// - Swap result to accumulator or file by bit
// - Table read loads ROM high byte, flags kept
// - Table read takes two instruction cycles
// - Pointer is high register low nibble over indirect low byte
`timescale 1ns/1ns
`default_nettype none
module sub_swap_tabrd
  import exec_unit_pkg::*;
(
  input  wire logic               CLOCK_I,         // Core clock
  input  wire logic               RESETN_I,        // Async reset, low
  input  wire logic               INSTR_VALID_I,   // Instruction present
  input  wire logic [INSTR_W-1:0] INSTR_I,         // Instruction word
  input  wire logic [DATA_W-1:0]  FILE_DATA_I,     // Addressed file value
  input  wire logic [DATA_W-1:0]  INDIRECT_ADDR_REG_I,    // Pointer low
  input  wire logic [DATA_W-1:0]  TABLE_POINTER_HIGH_REG_I, // Pointer high
  input  wire logic [ROM_W-1:0]   ROM_DATA_I,      // Program-memory word
  output logic                    BUSY_O,          // Table read in progress
  output logic [ROM_AW-1:0]       ROM_ADDR_O,      // Table pointer
  output logic                    ROM_RD_O,        // Program-memory read
  output logic [DATA_W-1:0]       ACC_O,           // Working accumulator
  output logic                    FILE_WE_O,       // File write strobe
  output logic [FADDR_W-1:0]      FILE_ADDR_O,     // File write address
  output logic [DATA_W-1:0]       FILE_WDATA_O,    // File write data
  output logic                    CARRY_FLAG_O,    // Carry flag
  output logic                    HALF_CARRY_FLAG_O, // Digit carry flag
  output logic                    ZERO_FLAG_O      // Zero flag
);
  typedef enum logic {IDLE, FETCH} tr_state_e;     // Table read states

  logic [DATA_W-1:0]  diff, swap;                 // ALU results
  logic               c_new, h_new, z_new;        // ALU flags
  logic               is_sub, is_swap, is_trh;    // Decodes
  logic               dest_file;                  // Destination bit

  tr_state_e          state_reg, state_next;      // Table read state
  logic [1:0]         cnt_reg, cnt_next;          // Cycle counter
  logic               busy_reg, busy_next;
  logic [ROM_AW-1:0]  addr_reg, addr_next;
  logic               rd_reg, rd_next;
  logic [DATA_W-1:0]  acc_reg, acc_next;
  logic               we_reg, we_next;
  logic [FADDR_W-1:0] fa_reg, fa_next;
  logic [DATA_W-1:0]  fd_reg, fd_next;
  logic               c_reg, c_next, h_reg, h_next, z_reg, z_next;

  // Arithmetic for both file operations
  nibble_sub_alu u_alu (
    .file_i  (FILE_DATA_I),
    .acc_i   (acc_reg),
    .diff_o  (diff),
    .swap_o  (swap),
    .carry_o (c_new),
    .half_o  (h_new),
    .zero_o  (z_new)
  );

  // Opcode decode, ignored while table read busy
  always_comb begin
    is_sub    = INSTR_VALID_I && !busy_reg && (INSTR_I[OP_HI:OP_LO] == OPC_SUB);
    is_swap   = INSTR_VALID_I && !busy_reg && (INSTR_I[OP_HI:OP_LO] == OPC_SWAP);
    is_trh    = INSTR_VALID_I && !busy_reg && (INSTR_I == OPC_TRH);
    dest_file = INSTR_I[DEST_BIT];
  end

  // Next values for accumulator, file port, flags and table read
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    addr_next  = addr_reg;
    rd_next    = 1'b0;
    acc_next   = acc_reg;
    we_next    = 1'b0;
    fa_next    = fa_reg;
    fd_next    = fd_reg;
    c_next     = c_reg;
    h_next     = h_reg;
    z_next     = z_reg;
    unique case (state_reg)
      IDLE: begin
        if (is_sub) begin
          c_next = c_new;
          h_next = h_new;
          z_next = z_new;
          if (dest_file) begin
            we_next = 1'b1;
            fa_next = INSTR_I[FADDR_W-1:0];
            fd_next = diff;
          end else begin
            acc_next = diff;
          end
        end else if (is_swap) begin
          if (dest_file) begin
            we_next = 1'b1;
            fa_next = INSTR_I[FADDR_W-1:0];
            fd_next = swap;
          end else begin
            acc_next = swap;
          end
        end else if (is_trh) begin
          // Pointer: high register low nibble over indirect low byte, truncated to 12 bits
          addr_next  = ROM_AW'({TABLE_POINTER_HIGH_REG_I,
                                INDIRECT_ADDR_REG_I});
          rd_next    = 1'b1;
          busy_next  = 1'b1;
          cnt_next   = 2'h0;
          state_next = FETCH;
        end
      end
      FETCH: begin
        // Second cycle captures the ROM word
        // Memory answers one cycle after the read pulse, so wait out cycle one
        if (cnt_reg == TRH_LAST) begin
          acc_next   = {2'b00, ROM_DATA_I[ROM_W-1:DATA_W]};
          busy_next  = 1'b0;
          state_next = IDLE;
        end
        cnt_next = cnt_reg + 2'h1;
      end
    endcase
  end

  // State registers
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_reg <= IDLE;
      cnt_reg   <= 2'h0;
      busy_reg  <= 1'b0;
      addr_reg  <= '0;
      rd_reg    <= 1'b0;
      acc_reg   <= ACC_RESET;
      we_reg    <= 1'b0;
      fa_reg    <= '0;
      fd_reg    <= '0;
      c_reg     <= 1'b0;
      h_reg     <= 1'b0;
      z_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      acc_reg   <= acc_next;
      we_reg    <= we_next;
      fa_reg    <= fa_next;
      fd_reg    <= fd_next;
      c_reg     <= c_next;
      h_reg     <= h_next;
      z_reg     <= z_next;
    end
  end

  // Outputs straight from flip-flops
  assign BUSY_O            = busy_reg;
  assign ROM_ADDR_O        = addr_reg;
  assign ROM_RD_O          = rd_reg;
  assign ACC_O             = acc_reg;
  assign FILE_WE_O         = we_reg;
  assign FILE_ADDR_O       = fa_reg;
  assign FILE_WDATA_O      = fd_reg;
  assign CARRY_FLAG_O      = c_reg;
  assign HALF_CARRY_FLAG_O = h_reg;
  assign ZERO_FLAG_O       = z_reg;

  // Subtract to accumulator lands the difference next cycle
  property p_sub_acc;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      (is_sub && !dest_file) |=> (ACC_O == $past(FILE_DATA_I) - $past(acc_reg));
  endproperty
  a_sub_acc: assert property (p_sub_acc) else $error("sub acc wrong");

  // Subtract flags follow the operands
  property p_sub_flags;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_sub |=> (CARRY_FLAG_O == ($past(FILE_DATA_I) >= $past(acc_reg)))
             && (ZERO_FLAG_O == ($past(FILE_DATA_I) == $past(acc_reg)))
             && (HALF_CARRY_FLAG_O == ($past(FILE_DATA_I[3:0]) >= $past(acc_reg[3:0])));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("sub flags wrong");

  // Subtract to file writes the file, accumulator kept
  property p_sub_file;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      (is_sub && dest_file) |=> FILE_WE_O && $stable(ACC_O)
        && (FILE_WDATA_O == $past(FILE_DATA_I) - $past(acc_reg));
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("sub file wrong");

  // Swap exchanges nibbles and keeps flags
  property p_swap;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_swap |=> $stable({CARRY_FLAG_O, HALF_CARRY_FLAG_O, ZERO_FLAG_O})
        && (FILE_WE_O ? FILE_WDATA_O : ACC_O)
           == {$past(FILE_DATA_I[3:0]), $past(FILE_DATA_I[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  // Swap destination follows the bit
  property p_swap_dest;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_swap |=> (FILE_WE_O == $past(dest_file));
  endproperty
  a_swap_dest: assert property (p_swap_dest) else $error("swap dest wrong");

  // Table read busy exactly two cycles
  property p_trh_len;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_trh |=> BUSY_O ##1 BUSY_O ##1 !BUSY_O;
  endproperty
  a_trh_len: assert property (p_trh_len) else $error("table read length wrong");

  // Pointer formed from both registers
  property p_trh_addr;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_trh |=> ROM_RD_O && (ROM_ADDR_O == ROM_AW'({$past(TABLE_POINTER_HIGH_REG_I),
                                                    $past(INDIRECT_ADDR_REG_I)}));
  endproperty
  a_trh_addr: assert property (p_trh_addr) else $error("pointer wrong");

  // High byte loaded zero-extended, flags kept
  property p_trh_data;
    @(posedge CLOCK_I) disable iff (!RESETN_I)
      is_trh |=> ##2 (ACC_O == {2'b00, $past(ROM_DATA_I[13:8])})
        && $stable(ZERO_FLAG_O) && $stable(CARRY_FLAG_O) && $stable(HALF_CARRY_FLAG_O);
  endproperty
  a_trh_data: assert property (p_trh_data) else $error("table data wrong");
endmodule // sub_swap_tabrd
`default_nettype wire

// [sim/tb.sv]
/*
  Self-checking bench for the subtract, nibble swap and table read block.
  Assumes the package and the block are compiled ahead of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import exec_unit_pkg::*;
  logic               clock = 1'b0;   // Core clock, 40 ns
  logic               resetn;         // Reset, active low
  logic               instr_valid;    // Instruction present
  logic [INSTR_W-1:0] instr;          // Instruction word
  logic [DATA_W-1:0]  file_data;      // Addressed file value
  logic [DATA_W-1:0]  ptr_lo;         // Pointer low byte
  logic [DATA_W-1:0]  ptr_hi;         // Pointer high byte
  logic [ROM_W-1:0]   rom_data;       // Program-memory word
  logic               busy, rom_rd, file_we, carry, half, zero;
  logic [ROM_AW-1:0]  rom_addr;       // Table pointer out
  logic [DATA_W-1:0]  acc, file_wdata;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0]  acc_exp;        // Accumulator model
  logic [2:0]         flags_exp;      // Carry, half, zero model
  logic [5:0]         opc;
  int                 failures = 0, checked = 0, cycles = 0;

  sub_swap_tabrd sub_swap_tabrd_inst (
    .CLOCK_I(clock), .RESETN_I(resetn), .INSTR_VALID_I(instr_valid), .INSTR_I(instr),
    .FILE_DATA_I(file_data), .INDIRECT_ADDR_REG_I(ptr_lo),
    .TABLE_POINTER_HIGH_REG_I(ptr_hi), .ROM_DATA_I(rom_data), .BUSY_O(busy),
    .ROM_ADDR_O(rom_addr), .ROM_RD_O(rom_rd), .ACC_O(acc), .FILE_WE_O(file_we),
    .FILE_ADDR_O(file_addr), .FILE_WDATA_O(file_wdata), .CARRY_FLAG_O(carry),
    .HALF_CARRY_FLAG_O(half), .ZERO_FLAG_O(zero));

  // Clock generator
  initial begin
    forever #20 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  // One comparison, counted
  task automatic chk(input bit ok, input string what);
    checked++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle instruction, valid left high for back-to-back use
  task automatic exec_op(input logic [5:0] op, input logic d, input logic [6:0] f,
                         input logic [7:0] v);
    logic [7:0] res;
    logic       known;
    instr_valid = 1'b1;
    instr = {op, d, f};
    file_data = v;
    @(posedge clock);
    #1;
    known = (op == OPC_SUB) || (op == OPC_SWAP);
    res = (op == OPC_SUB) ? v - acc_exp : {v[3:0], v[7:4]};
    if (op == OPC_SUB) begin
      flags_exp = {v >= acc_exp, v[3:0] >= acc_exp[3:0], res == 8'h00};
    end
    if (known && !d) begin
      acc_exp = res;
    end
    chk(acc === acc_exp, "accumulator");
    chk(file_we === (known && d), "file strobe");
    if (known && d) begin
      chk(file_addr === f && file_wdata === res, "file write");
    end
    chk({carry, half, zero} === flags_exp, "flags");
    chk(rom_rd === 1'b0, "stray program read");
  endtask

  // Table read with a subtract offered while busy
  task automatic table_read(input logic [7:0] lo, input logic [7:0] hi,
                            input logic [13:0] word);
    int n;
    instr_valid = 1'b1;
    instr = OPC_TRH;
    ptr_lo = lo;
    ptr_hi = hi;
    @(posedge clock);
    #1;
    instr = {OPC_SUB, 1'b1, 7'h11};
    rom_data = word;
    chk(rom_rd === 1'b1 && rom_addr === {hi[3:0], lo}, "pointer");
    n = 0;
    while (busy === 1'b1 && n < 4) begin
      chk(file_we === 1'b0, "taken while busy");
      n++;
      @(posedge clock);
      #1;
    end
    // Subtract offered on the last busy edge must still be ignored
    chk(file_we === 1'b0, "taken while busy");
    instr = 14'h3f00;
    rom_data = ~word;
    acc_exp = {2'b00, word[13:8]};
    chk(n == TRH_CYCLES, "table read length");
    chk(acc === acc_exp, "table data");
    chk({carry, half, zero} === flags_exp, "flags kept");
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    file_data = '0;
    ptr_lo = '0;
    ptr_hi = '0;
    rom_data = 14'h2aaa;
    acc_exp = ACC_RESET;
    flags_exp = 3'h0;
    void'($urandom(32'hf329));
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    chk(acc === ACC_RESET && {carry, half, zero, file_we, busy} === 5'h00, "reset");
    // Corner cases: no borrow, zero, borrow, half borrow
    exec_op(OPC_SWAP, 1'b0, 7'h05, 8'h20);
    exec_op(OPC_SUB, 1'b1, 7'h10, 8'h03);
    exec_op(OPC_SUB, 1'b1, 7'h10, 8'h02);
    exec_op(OPC_SUB, 1'b1, 7'h7f, 8'h01);
    exec_op(OPC_SWAP, 1'b0, 7'h7f, 8'h5a);
    exec_op(OPC_SUB, 1'b0, 7'h00, 8'h1f);
    exec_op(OPC_SUB, 1'b0, 7'h00, 8'h80);
    table_read(8'h34, 8'h02, 14'h3789);
    table_read(8'hff, 8'hff, 14'h3fff);
    // Random mix, back to back
    repeat (80) begin
      case ($urandom_range(2, 0))
        0: opc = OPC_SUB;
        1: opc = OPC_SWAP;
        default: opc = 6'($urandom_range(63, 1));
      endcase
      exec_op(opc, 1'($urandom), 7'($urandom), 8'($urandom));
      if ($urandom_range(7, 0) == 0) begin
        table_read(8'($urandom), 8'($urandom), 14'($urandom));
      end
    end
    instr_valid = 1'b0;
    @(posedge clock);
    #1;
    complete_run();
  end
endmodule // tb
`default_nettype wire
